/* rtl/quad_dac_pkg.sv */
// constants, field positions and types for the quad converter command decoder
// assumes a 24-bit serial frame and a 32-bit ahb-lite register window
//
// How it works
// - 24 bits, msb first, falling clock edges
// - store data code into selected buffer only
// - store power-down command into selected buffer
// - data to buffer and selected output register
// - power-down to buffer and selected output register
// - data to buffer, then all outputs load
// - power-down to buffer, then all outputs load
// - broadcast without data reloads all outputs
// - broadcast data to every buffer and output
// - broadcast power-down to every buffer and output
// - broadcast ignores top bits and select low
// - execute on 24th edge, no strobe wait
// - early strobe rise clears the shift register
// - aborted frame changes no channel state
// - power-down mode taken from two code bits
// - lock after 24 bits until strobe rises
`default_nettype none
package quad_dac_pkg;
   localparam int FRAME_BITS = 24;
   localparam int CNT_W = 5;
   localparam int NUM_CH = 4;
   localparam int CODE_W = 12;
   // field positions inside the serial word
   localparam int LD_HI_BIT = 21;
   localparam int LD_LO_BIT = 20;
   localparam int SEL_HI_BIT = 18;
   localparam int SEL_LO_BIT = 17;
   localparam int PD_BIT = 16;
   localparam int DATA_MSB = 15;
   localparam int DATA_LSB = 4;
   // power-down mode sits in the two top code bits
   localparam int MODE_HI_IN_CODE = 11;
   localparam int MODE_LO_IN_CODE = 10;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_LOAD = 8'h0c;
   localparam logic [3:0] PAGE_BUF = 4'h1;
   localparam logic [3:0] PAGE_DAC = 4'h2;
   localparam logic [7:0] OFS_MODES = 8'h30;
   // reset values
   localparam logic CTRL_EN_RST = 1'h1;
   localparam logic [23:0] WORD_RST = 24'h000000;
   localparam logic [15:0] FRAME_CNT_RST = 16'h0000;
   localparam logic [7:0] DROP_CNT_RST = 8'h00;
   // output modes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_1K = 2'h1;
   localparam logic [1:0] MODE_100K = 2'h2;
   localparam logic [1:0] MODE_HIZ = 2'h3;

   // one storage element: a code, or a power-down mode when pd is set
   typedef struct packed {
      logic pd;
      logic [CODE_W-1:0] code;
   } chan_entry_t;
   localparam chan_entry_t ENTRY_RST = 13'h0000;

   typedef enum logic [1:0] {LOAD_STORE, LOAD_SINGLE, LOAD_SIMUL, LOAD_BCAST} load_kind_t;
endpackage
`default_nettype wire

/* rtl/cmd_xfer_if.sv */
// carries a completed serial word and its toggle from the link to the core
// assumes the word is stable whenever the toggle has flipped
`default_nettype none
interface cmd_xfer_if;
   logic [23:0] word;
   logic toggle;
   modport rx (output word, output toggle);
   modport core (input word, input toggle);
endinterface
`default_nettype wire

/* rtl/serial_receiver.sv */
// serial shift logic running on the link clock
// assumes strobe and data come from the host; the link clock may stop between frames
`default_nettype none
module serial_receiver
   import quad_dac_pkg::*;
(
   input wire logic sclk,
   input wire logic hresetn,
   input wire logic sync_n,
   input wire logic din,
   cmd_xfer_if.rx link
);
   logic frame_clr;
   logic [CNT_W-1:0] bit_cnt_q;
   logic [FRAME_BITS-2:0] input_shift_word;
   logic [23:0] word_q;
   logic toggle_q;

   // strobe high clears the frame state, so an early rise discards the bits
   assign frame_clr = sync_n | ~hresetn;

   // shift on falling edges, msb first, then lock at 24 bits
   always_ff @(negedge sclk or posedge frame_clr) begin
      if (frame_clr) begin
         bit_cnt_q <= 5'h00;
         input_shift_word <= 23'h000000;
      end else if (bit_cnt_q < CNT_W'(FRAME_BITS)) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
         input_shift_word <= {input_shift_word[FRAME_BITS-3:0], din};
      end
   end

   // completed word and its toggle survive an abort
   always_ff @(negedge sclk or negedge hresetn) begin
      if (!hresetn) begin
         word_q <= WORD_RST;
         toggle_q <= 1'h0;
      end else if (!sync_n && bit_cnt_q == CNT_W'(FRAME_BITS - 1)) begin
         word_q <= {input_shift_word, din};
         toggle_q <= ~toggle_q;
      end
   end

   assign link.word = word_q;
   assign link.toggle = toggle_q;
endmodule
`default_nettype wire

/* rtl/toggle_sync.sv */
// brings the link toggle into the bus clock and makes a one-cycle event
// assumes the toggle flips at most once per serial frame
`default_nettype none
module toggle_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tog_in,
   output logic evt
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic seen_q;

   // three-stage chain, first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 1'h0;
         s2_q <= 1'h0;
         s3_q <= 1'h0;
      end else begin
         s1_q <= tog_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once stages two and three agree
   assign evt = (s2_q == s3_q) && (s3_q != seen_q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_q <= 1'h0;
      end else if (evt) begin
         seen_q <= s3_q;
      end
   end
endmodule
`default_nettype wire

/* rtl/quad_dac_cmd_top.sv */
// command decoder core: ahb-lite registers, frame hand-over and channel storage
// assumes a single ahb-lite master and a host serial master on sclk/sync_n/din
`default_nettype none
module quad_dac_cmd_top (
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial link
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   // channel state towards the analog side
   output var quad_dac_pkg::chan_entry_t [3:0] dac_state,
   output logic [3:0][1:0] chan_mode,
   output logic cmd_done
);
   import quad_dac_pkg::*;

   cmd_xfer_if xfer ();

   // link side
   serial_receiver u_rx (
      .sclk (sclk),
      .hresetn (hresetn),
      .sync_n (sync_n),
      .din (din),
      .link (xfer.rx)
   );

   logic ser_evt;

   // word arrival crosses by toggle
   toggle_sync u_sync (
      .hclk (hclk),
      .hresetn (hresetn),
      .tog_in (xfer.toggle),
      .evt (ser_evt)
   );

   // storage, one buffer and one output register per channel
   chan_entry_t buf_q [NUM_CH];

   // bus state
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic wr_hit_q;
   logic addr_phase;
   logic addr_hit;
   logic wr_now;

   // software state
   logic ctrl_en_q;
   logic [23:0] sw_word_q;
   logic sw_pend_q;
   logic load_pulse_q;

   // execution state
   logic [23:0] exec_word_q;
   logic exec_go_q;
   logic [23:0] last_word_q;
   logic [15:0] frame_cnt_q;
   logic [7:0] drop_cnt_q;
   logic ser_take;
   logic sw_take;
   logic load_go;

   // decoded fields of the word being executed
   load_kind_t exec_kind;
   logic [1:0] exec_sel;
   chan_entry_t exec_entry;

   // turn a serial word into a storage element
   function automatic chan_entry_t entry_of(input logic [23:0] w);
      chan_entry_t e;
      e.pd = w[PD_BIT];
      e.code = w[DATA_MSB:DATA_LSB];
      return e;
   endfunction

   // aligned word inside a per-channel register page
   function automatic logic page_hit(input logic [7:0] a, input logic [3:0] page);
      return (a[7:4] == page) && (a[1:0] == 2'h0);
   endfunction

   // data phase of a write to one register
   function automatic logic wr_to(input logic [7:0] ofs);
      return wr_now && (wr_addr_q == ofs);
   endfunction

   // register read decode
   function automatic logic [31:0] reg_read(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h00000000;
      if (a == OFS_CTRL) begin
         r = {31'h00000000, ctrl_en_q};
      end else if (a == OFS_CMD) begin
         r = {8'h00, last_word_q};
      end else if (a == OFS_STATUS) begin
         r = {drop_cnt_q, 7'h00, sw_pend_q, frame_cnt_q};
      end else if (page_hit(a, PAGE_BUF)) begin
         r = {19'h00000, buf_q[a[3:2]]};
      end else if (page_hit(a, PAGE_DAC)) begin
         r = {19'h00000, dac_state[a[3:2]]};
      end else if (a == OFS_MODES) begin
         r = {24'h000000, chan_mode};
      end
      return r;
   endfunction

   // address phase taken when selected, ready and a transfer is requested
   assign addr_phase = hsel && hready && htrans[1];
   assign addr_hit = (haddr[31:8] == 24'h000000);
   assign wr_now = wr_pend_q && wr_hit_q;

   // zero-wait slave: ready after reset and ever after
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'h1;
      end else begin
         hreadyout <= 1'h1;
      end
   end

   // every response is okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'h0;
      end else begin
         hresp <= 1'h0;
      end
   end

   // capture the address phase of each transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'h0;
         wr_addr_q <= 8'h00;
         wr_hit_q <= 1'h0;
      end else if (addr_phase) begin
         wr_pend_q <= hwrite;
         wr_addr_q <= haddr[7:0];
         wr_hit_q <= addr_hit;
      end else if (hready) begin
         wr_pend_q <= 1'h0;
      end
   end

   // read data is ready for the data phase and stands until the next transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_phase) begin
         hrdata <= (!hwrite && addr_hit) ? reg_read(haddr[7:0]) : 32'h00000000;
      end
   end

   // serial enable bit; a cleared bit drops incoming frames
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en_q <= CTRL_EN_RST;
      end else if (wr_to(OFS_CTRL)) begin
         ctrl_en_q <= hwdata[0];
      end
   end

   // software command word; a new write wins over the take
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_word_q <= WORD_RST;
         sw_pend_q <= 1'h0;
      end else if (wr_to(OFS_CMD)) begin
         sw_word_q <= hwdata[23:0];
         sw_pend_q <= 1'h1;
      end else if (sw_take) begin
         sw_pend_q <= 1'h0;
      end
   end

   // software load of all outputs; held while a command executes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_pulse_q <= 1'h0;
      end else if (wr_to(OFS_LOAD) && hwdata[0]) begin
         load_pulse_q <= 1'h1;
      end else if (load_go) begin
         load_pulse_q <= 1'h0;
      end
   end

   // a command in the same cycle goes first, the load follows
   assign load_go = load_pulse_q && !exec_go_q;

   // serial frames take priority; software waits one slot
   assign ser_take = ser_evt && ctrl_en_q;
   assign sw_take = sw_pend_q && !ser_take;

   // kind, channel and storage element of the executing word
   assign exec_kind = load_kind_t'(exec_word_q[LD_HI_BIT:LD_LO_BIT]);
   assign exec_sel = exec_word_q[SEL_HI_BIT:SEL_LO_BIT];
   assign exec_entry = entry_of(exec_word_q);

   // latch the word to execute; the link word is stable after the toggle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exec_word_q <= WORD_RST;
         exec_go_q <= 1'h0;
      end else if (ser_take) begin
         exec_word_q <= xfer.word;
         exec_go_q <= 1'h1;
      end else if (sw_take) begin
         exec_word_q <= sw_word_q;
         exec_go_q <= 1'h1;
      end else begin
         exec_go_q <= 1'h0;
      end
   end

   // executed serial frames
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_cnt_q <= FRAME_CNT_RST;
      end else if (ser_take) begin
         frame_cnt_q <= frame_cnt_q + 16'h0001;
      end
   end

   // frames dropped while the serial enable is clear, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drop_cnt_q <= DROP_CNT_RST;
      end else if (ser_evt && !ctrl_en_q && drop_cnt_q != 8'hff) begin
         drop_cnt_q <= drop_cnt_q + 8'h01;
      end
   end

   // last executed word, serial or software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_word_q <= WORD_RST;
      end else if (exec_go_q) begin
         last_word_q <= exec_word_q;
      end
   end

   // data buffers; top bits and bit 19 are never looked at
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            buf_q[i] <= ENTRY_RST;
         end
      end else if (exec_go_q) begin
         case (exec_kind)
            LOAD_STORE, LOAD_SINGLE, LOAD_SIMUL: begin
               buf_q[exec_sel] <= exec_entry;
            end
            LOAD_BCAST: begin
               // select low bit is a don't-care here
               for (int i = 0; i < NUM_CH; i++) begin
                  if (exec_word_q[SEL_HI_BIT]) begin
                     buf_q[i] <= exec_entry;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // output registers; they read the buffers as they stood before the command
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            dac_state[i] <= ENTRY_RST;
         end
      end else if (exec_go_q) begin
         case (exec_kind)
            LOAD_SINGLE: begin
               dac_state[exec_sel] <= exec_entry;
            end
            LOAD_SIMUL: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (2'(i) == exec_sel) begin
                     dac_state[i] <= exec_entry;
                  end else begin
                     dac_state[i] <= buf_q[i];
                  end
               end
            end
            LOAD_BCAST: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (exec_word_q[SEL_HI_BIT]) begin
                     dac_state[i] <= exec_entry;
                  end else begin
                     dac_state[i] <= buf_q[i];
                  end
               end
            end
            default: begin
            end
         endcase
      end else if (load_go) begin
         for (int i = 0; i < NUM_CH; i++) begin
            dac_state[i] <= buf_q[i];
         end
      end
   end

   // operating mode of each output register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_mode <= {NUM_CH{MODE_NORMAL}};
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (dac_state[i].pd) begin
               chan_mode[i] <= dac_state[i].code[MODE_HI_IN_CODE:MODE_LO_IN_CODE];
            end else begin
               chan_mode[i] <= MODE_NORMAL;
            end
         end
      end
   end

   // one-cycle pulse as each command takes effect
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_done <= 1'h0;
      end else begin
         cmd_done <= exec_go_q || load_go;
      end
   end
endmodule
`default_nettype wire

/* dv/quad_dac_cmd_properties.sv */
// concurrent checks on the command decoder top ports
// assumes binding onto quad_dac_cmd_top, single bus clock domain
`default_nettype none
module quad_dac_cmd_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic sync_n,
   input wire quad_dac_pkg::chan_entry_t [3:0] dac_state,
   input wire logic [3:0][1:0] chan_mode,
   input wire logic cmd_done
);
   import quad_dac_pkg::*;
   logic [3:0] quiet_q;
   // cycles since the last frame strobe or bus request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_q <= 4'h0;
      end else if (!sync_n || (hsel && htrans[1])) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hf) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("bus ready dropped");
   a_done_follows: assert property (!$stable(dac_state) |-> cmd_done)
      else $error("no done pulse after channel update");
   a_done_pulse: assert property (cmd_done |=> !cmd_done)
      else $error("done pulse longer than one cycle");
   a_update_once: assert property (!$stable(dac_state) |=> $stable(dac_state) [*3])
      else $error("channels not updated together");
   a_quiet_stable: assert property (quiet_q >= 4'ha |-> $stable(dac_state))
      else $error("channel state changed without a command");
   a_done_recent: assert property (cmd_done |-> quiet_q < 4'ha)
      else $error("done pulse without recent command");
   for (genvar g = 0; g < 4; g++) begin : g_mode
      a_mode_follow: assert property (
         1'b1 |=> chan_mode[g] == ($past(dac_state[g].pd) ?
         $past(dac_state[g].code[11:10]) : 2'h0))
         else $error("channel mode does not follow state");
   end
endmodule
bind quad_dac_cmd_top quad_dac_cmd_properties props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hreadyout(hreadyout), .hresp(hresp), .sync_n(sync_n),
   .dac_state(dac_state), .chan_mode(chan_mode), .cmd_done(cmd_done));
`default_nettype wire

/* dv/host_serial.sv */
// host serial master model: strobe, link clock and data
// assumes frames are requested only after reset is released
`default_nettype none
module host_serial (
   output logic sclk,
   output logic sync_n,
   output logic din
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      din = 1'b0;
   end
   // n bits from bits[31] down; clock stands still outside frames
   task automatic frame(input logic [31:0] bits, input int n);
      int i;
      sync_n = 1'b0;
      for (i = 0; i < n; i++) begin
         #3 din = bits[31-i];
         #3 sclk = 1'b1;
         #6 sclk = 1'b0;
      end
      #6 din = ~din;
      sync_n = 1'b1;
      #12 din = ~din;
   endtask
endmodule
`default_nettype wire

/* dv/quad_dac_cmd_top_test.sv */
// self-checking bench: ahb-lite reads and serial commands from the host model
// assumes zero-wait bus answers and one host model on the link pins
`default_nettype none
module quad_dac_cmd_top_test;
   import quad_dac_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, sclk, sync_n, din, cmd_done;
   chan_entry_t [3:0] dac_state;
   logic [3:0][1:0] chan_mode;
   chan_entry_t buf_e [4] = '{default: ENTRY_RST};
   chan_entry_t dac_e [4] = '{default: ENTRY_RST};
   logic [11:0] codes [4] = '{12'hfff, 12'h001, 12'h800, 12'h5a5};
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   always #20 hclk = ~hclk;
   host_serial host (.sclk(sclk), .sync_n(sync_n), .din(din));
   quad_dac_cmd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk),
      .sync_n(sync_n), .din(din), .dac_state(dac_state), .chan_mode(chan_mode),
      .cmd_done(cmd_done));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one single ahb-lite word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   function automatic logic [23:0] wd(logic [1:0] lk, logic [1:0] ch, logic pd,
                                      logic [11:0] code);
      return {2'h0, lk, 1'b0, ch, pd, code, 4'ha};
   endfunction
   // expected buffers and outputs after a command word
   task automatic apply(input logic [23:0] w);
      chan_entry_t e;
      int c;
      e = {w[16], w[15:4]};
      c = w[18:17];
      if (w[21:20] == 2'h3) begin
         for (int i = 0; i < 4; i++) begin
            if (w[18]) buf_e[i] = e;
            dac_e[i] = buf_e[i];
         end
      end else begin
         buf_e[c] = e;
         if (w[21:20] == 2'h1) dac_e[c] = e;
         if (w[21:20] == 2'h2) dac_e = buf_e;
      end
   endtask
   task automatic wait_done();
      int i;
      i = 0;
      while (cmd_done !== 1'b1 && i < 40) begin
         @(posedge hclk);
         #1;
         i++;
      end
      check("cmd_done", 32'h1, {31'h0, cmd_done});
   endtask
   task automatic cmd(input logic [23:0] w);
      host.frame({w, 8'h00}, 24);
      apply(w);
      wait_done();
   endtask
   task automatic check_all();
      logic [1:0] m;
      logic [7:0] modes;
      for (int i = 0; i < 4; i++) begin
         m = dac_e[i].pd ? dac_e[i].code[11:10] : 2'h0;
         modes[2 * i +: 2] = m;
         bus(1'b0, 8'h10 + 8'(4 * i), 32'h0);
         check("buffer", {19'h0, buf_e[i]}, rd);
         bus(1'b0, 8'h20 + 8'(4 * i), 32'h0);
         check("dac reg", {19'h0, dac_e[i]}, rd);
         check("dac_state", {19'h0, dac_e[i]}, {19'h0, dac_state[i]});
         check("chan_mode", {30'h0, m}, {30'h0, chan_mode[i]});
      end
      bus(1'b0, OFS_MODES, 32'h0);
      check("modes", {24'h0, modes}, rd);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      check_all();
      bus(1'b0, OFS_CTRL, 32'h0);
      check("ctrl", 32'h1, rd);
      bus(1'b0, 8'h40, 32'h0);
      check("unmapped", 32'h0, rd);
      $display("done reset");
      for (int i = 0; i < 4; i++) cmd(wd(2'h0, 2'(i), 1'b0, codes[i]));
      cmd(wd(2'h0, 2'h1, 1'b1, 12'h400));
      check_all();
      $display("done store");
      cmd(wd(2'h1, 2'h2, 1'b0, 12'h123));
      cmd(wd(2'h1, 2'h3, 1'b1, 12'hea9));
      check_all();
      $display("done single");
      cmd(wd(2'h0, 2'h0, 1'b0, 12'h456));
      cmd(wd(2'h2, 2'h1, 1'b1, 12'h800));
      check_all();
      cmd(wd(2'h2, 2'h2, 1'b0, 12'h777));
      check_all();
      $display("done simultaneous");
      cmd(wd(2'h0, 2'h3, 1'b0, 12'h9ab));
      cmd({2'h3, 2'h3, 1'b0, 1'b0, 1'b1, 1'b1, 12'hfff, 4'h5});
      check_all();
      cmd({2'h3, 2'h3, 1'b0, 1'b1, 1'b1, 1'b0, 12'h4c3, 4'h0});
      check_all();
      cmd({2'h0, 2'h3, 1'b0, 1'b1, 1'b0, 1'b1, 12'h7ff, 4'h0});
      check_all();
      $display("done broadcast");
      host.frame({wd(2'h3, 2'h2, 1'b0, 12'hbad), 8'h00}, 23);
      repeat (12) @(posedge hclk);
      check_all();
      host.frame({wd(2'h1, 2'h1, 1'b0, 12'h321), 8'hff}, 30);
      apply(wd(2'h1, 2'h1, 1'b0, 12'h321));
      wait_done();
      check_all();
      $display("done abort");
      bus(1'b1, OFS_CMD, {8'h0, wd(2'h1, 2'h2, 1'b1, 12'h800)});
      apply(wd(2'h1, 2'h2, 1'b1, 12'h800));
      wait_done();
      check_all();
      $display("done software command");
      bus(1'b0, OFS_CMD, 32'h0);
      check("last word", {8'h0, wd(2'h1, 2'h2, 1'b1, 12'h800)}, rd);
      bus(1'b1, OFS_CTRL, 32'h0);
      host.frame({wd(2'h3, 2'h2, 1'b0, 12'h0f0), 8'h00}, 24);
      repeat (12) @(posedge hclk);
      bus(1'b0, OFS_STATUS, 32'h0);
      check("status", 32'h0100000f, rd);
      bus(1'b1, OFS_CTRL, 32'h1);
      cmd(wd(2'h0, 2'h1, 1'b0, 12'h0c3));
      bus(1'b1, OFS_LOAD, 32'h1);
      dac_e = buf_e;
      wait_done();
      check_all();
      $display("done control registers");
      summarize();
   end
endmodule
`default_nettype wire
